/* hw/eeprom_config_loader.sv */
// Reset-time serial EEPROM configuration loader with register port
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module eeprom_config_loader
    import eeprom_loader_pkg::*;
#(
    parameter int SK_HALF = SK_HALF_CYC,
    parameter bit LATER_STEP = 1'b1,
    parameter logic [7:0] REV_ID_BASE = 8'h00
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic ee_cs,
    output logic ee_sk,
    output logic ee_di,
    input wire logic ee_do,
    input wire logic isolate_pin_n,
    output logic clk_isolate,
    input wire logic wake_packet_rx,
    output logic wake_event_out_n,
    input wire logic station_address_setup_cmd,
    input wire logic [47:0] setup_address,
    input wire logic rev_sub_strap,
    output logic [1:0] phy_addr,
    output logic wake_on_lan_enable,
    output logic cap_ptr_zero,
    output logic boot_rom_disable,
    output logic subsys_id_sel,
    output logic [7:0] revision_id,
    output logic [15:0] subsystem_id,
    output logic [15:0] subsystem_vendor_id,
    output logic [47:0] station_address,
    output logic load_done
);
    import eeprom_loader_pkg::*;

    // Word address for each step of the load sequence
    function automatic logic [5:0] word_addr(input logic [2:0] idx);
        case (idx)
            3'h0: word_addr = EE_ADDR_CFG;
            3'h1: word_addr = EE_ADDR_SUBSYS;
            3'h2: word_addr = EE_ADDR_VENDOR;
            3'h3: word_addr = EE_ADDR_SA0;
            3'h4: word_addr = EE_ADDR_SA1;
            default: word_addr = EE_ADDR_SA2;
        endcase
    endfunction

    load_state_t state_reg;
    logic [9:0] half_cnt_reg;
    logic [4:0] bit_cnt_reg;
    logic [2:0] word_idx_reg;
    logic [15:0] shift_reg, cfg_reg, subsys_reg, vendor_reg;
    logic [47:0] sa_ee_reg, sa_sw_reg;
    logic sk_reg, sa_sw_valid_reg, done_reg, wake_reg;
    logic do_s1_reg, do_s2_reg, iso_s1_reg, iso_s2_reg;
    logic half_tick, gap_tick, bit_end, word_end;
    logic cfg_valid, last_word, reload_req, wake_clr;
    logic [15:0] word_next;
    logic [8:0] cmd_word;

    assign half_tick = (half_cnt_reg == 10'(SK_HALF - 1));
    assign gap_tick = (half_cnt_reg == 10'(2 * SK_HALF - 1));
    assign bit_end = (state_reg == S_SHIFT) && half_tick && sk_reg;
    assign word_end = bit_end && (bit_cnt_reg == 5'(WORD_BITS - 1));
    assign word_next = {shift_reg[14:0], do_s2_reg};
    assign cmd_word = {START_BIT, READ_OPCODE, word_addr(word_idx_reg)};
    assign cfg_valid = (cfg_reg[CFG_SIG_LSB +: 2] == SIG_VALID);
    // Address words follow only for a valid word with the wake bit set
    assign last_word = (word_idx_reg == LAST_IDX_WOL) ||
        ((word_idx_reg == LAST_IDX_BASE) &&
        !(cfg_valid && cfg_reg[CFG_WOL_BIT]));
    assign reload_req = reg_wr && (reg_addr == REG_CONTROL) &&
        reg_wdata[CTL_RELOAD] && done_reg;
    assign wake_clr = reg_wr && (reg_addr == REG_CONTROL) &&
        reg_wdata[CTL_WAKE_CLR];

    // Pin synchronisers; first stages feed only the second stages
    // No reset: both outputs are only used once the load is under way
    always_ff @(posedge clk)
    begin
        do_s1_reg <= ee_do;
        do_s2_reg <= do_s1_reg;
        iso_s1_reg <= isolate_pin_n;
        iso_s2_reg <= iso_s1_reg;
    end

    // Sequencer; reset release starts the load with the config word
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= S_SHIFT;
            half_cnt_reg <= 10'h000;
            bit_cnt_reg <= 5'h00;
            word_idx_reg <= 3'h0;
            done_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                S_SHIFT:
                begin
                    half_cnt_reg <= half_tick ? 10'h000 : half_cnt_reg + 10'h001;
                    if (word_end)
                    begin
                        bit_cnt_reg <= 5'h00;
                        state_reg <= S_GAP;
                    end
                    else if (bit_end)
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                end
                S_GAP:
                begin
                    // Chip select stays low for one bit period between words
                    half_cnt_reg <= gap_tick ? 10'h000 : half_cnt_reg + 10'h001;
                    if (gap_tick && last_word)
                    begin
                        state_reg <= S_DONE;
                        done_reg <= 1'b1;
                    end
                    else if (gap_tick)
                    begin
                        word_idx_reg <= word_idx_reg + 3'h1;
                        state_reg <= S_SHIFT;
                    end
                end
                S_DONE:
                begin
                    half_cnt_reg <= 10'h000;
                    if (reload_req)
                    begin
                        word_idx_reg <= 3'h0;
                        done_reg <= 1'b0;
                        state_reg <= S_SHIFT;
                    end
                end
                default:
                begin
                    state_reg <= S_DONE;
                    done_reg <= 1'b1;
                end
            endcase
        end
    end

    // Serial pins; data changes while the shift clock is low
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sk_reg <= 1'b0;
            ee_cs <= 1'b0;
            ee_di <= 1'b0;
        end
        else
        begin
            if (state_reg == S_SHIFT && half_tick)
                sk_reg <= !sk_reg;
            else if (state_reg != S_SHIFT)
                sk_reg <= 1'b0;
            ee_cs <= (state_reg == S_SHIFT);
            if (state_reg == S_SHIFT && bit_cnt_reg < 5'(CMD_BITS))
                ee_di <= cmd_word[4'(CMD_BITS - 1) - bit_cnt_reg[3:0]];
            else
                ee_di <= 1'b0;
        end
    end
    assign ee_sk = sk_reg;

    // Data bits sampled at the end of each high phase, MSB first
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            shift_reg <= 16'h0000;
        else if (bit_end && bit_cnt_reg >= 5'(CMD_BITS + DUMMY_BITS))
            shift_reg <= word_next;
    end

    // Loaded words; config stays at reset value until read
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cfg_reg <= CFG_RESET;
            subsys_reg <= 16'h0000;
            vendor_reg <= 16'h0000;
            sa_ee_reg <= 48'h000000000000;
        end
        else if (word_end)
        begin
            case (word_idx_reg)
                3'h0: cfg_reg <= word_next;
                3'h1: subsys_reg <= word_next;
                3'h2: vendor_reg <= word_next;
                3'h3: sa_ee_reg[15:0] <= word_next;
                3'h4: sa_ee_reg[31:16] <= word_next;
                default: sa_ee_reg[47:32] <= word_next;
            endcase
        end
    end

    // Software address setup replaces the loaded address from then on
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sa_sw_reg <= 48'h000000000000;
            sa_sw_valid_reg <= 1'b0;
        end
        else if (station_address_setup_cmd)
        begin
            sa_sw_reg <= setup_address;
            sa_sw_valid_reg <= 1'b1;
        end
    end

    // Decoded configuration; reserved bits 4:2, 6, 12 are ignored
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            phy_addr <= PHY_ADDR_DEFAULT;
            wake_on_lan_enable <= 1'b0;
            cap_ptr_zero <= 1'b0;
            boot_rom_disable <= 1'b0;
            subsys_id_sel <= 1'b0;
            revision_id <= REV_ID_BASE;
            station_address <= 48'h000000000000;
            load_done <= 1'b0;
        end
        else
        begin
            phy_addr <= cfg_valid ? cfg_reg[CFG_PHY_LSB +: 2]
                : PHY_ADDR_DEFAULT;
            wake_on_lan_enable <= cfg_valid && cfg_reg[CFG_WOL_BIT];
            cap_ptr_zero <= cfg_valid && cfg_reg[CFG_PM_BIT];
            boot_rom_disable <= cfg_valid && cfg_reg[CFG_BOOT_BIT];
            subsys_id_sel <= cfg_valid && cfg_reg[CFG_ID_BIT];
            // Later step also demands the ID bit before substituting
            if (LATER_STEP ? (cfg_reg[CFG_ID_BIT +: 3] == SIG_ID_LATER &&
                rev_sub_strap) : (cfg_valid && rev_sub_strap))
                revision_id <= {REV_ID_BASE[7:3], cfg_reg[CFG_REV_LSB +: 3]};
            else
                revision_id <= REV_ID_BASE;
            station_address <= sa_sw_valid_reg ? sa_sw_reg
                : sa_ee_reg;
            load_done <= done_reg;
        end
    end
    assign subsystem_id = subsys_reg;
    assign subsystem_vendor_id = vendor_reg;

    // Wake event is sticky; a new packet beats a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            wake_reg <= 1'b0;
        else if (wake_packet_rx && wake_on_lan_enable && done_reg)
            wake_reg <= 1'b1;
        else if (wake_clr)
            wake_reg <= 1'b0;
    end
    assign wake_event_out_n = !wake_reg;

    // Isolation may gate the clock only once every EEPROM access ended
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            clk_isolate <= 1'b0;
        else
            clk_isolate <= done_reg && !iso_s2_reg;
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                REG_STATUS: reg_rdata <= {11'h000, sa_sw_valid_reg, wake_reg,
                    wake_on_lan_enable, cfg_valid, done_reg};
                REG_CONFIG: reg_rdata <= cfg_reg;
                REG_SA0: reg_rdata <= station_address[15:0];
                REG_SA1: reg_rdata <= station_address[31:16];
                REG_SA2: reg_rdata <= station_address[47:32];
                REG_SUBSYS: reg_rdata <= subsys_reg;
                REG_VENDOR: reg_rdata <= vendor_reg;
                default: reg_rdata <= 16'h0000;
            endcase
        end
        else
            reg_rdata <= 16'h0000;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_phy_default_sel: assert property (
        !cfg_valid |=> phy_addr == PHY_ADDR_DEFAULT)
        else $error("PHY address not default without signature");
    a_phy_from_word: assert property (
        cfg_valid |=> phy_addr == $past(cfg_reg[1:0]))
        else $error("PHY address not taken from config word");
    a_wol_needs_sig: assert property (
        wake_on_lan_enable |-> $past(cfg_valid))
        else $error("Wake mode set without valid signature");
    a_pm_cap_zero: assert property (
        (cfg_valid && cfg_reg[7]) |=> cap_ptr_zero)
        else $error("Capability pointer not forced to zero");
    a_boot_rom_off: assert property (
        (cfg_valid && cfg_reg[11]) |=> boot_rom_disable)
        else $error("Expansion ROM not disabled");
    a_rev_later_step: assert property (
        (LATER_STEP && cfg_reg[15:13] != 3'h3) |=> revision_id == REV_ID_BASE)
        else $error("Revision substituted without 011b");
    a_wake_after_load: assert property (
        $fell(wake_event_out_n) |->
        $past(wake_packet_rx && wake_on_lan_enable && done_reg))
        else $error("Wake output without loaded wake mode");
    a_isolate_blocked: assert property (
        !done_reg |=> !clk_isolate)
        else $error("Clock isolated before load finished");
    a_word_count_end: assert property (
        $rose(done_reg) |-> (word_idx_reg == 3'h5 && $past(cfg_valid &&
        cfg_reg[5])) || (word_idx_reg == 3'h2 && !(cfg_valid && cfg_reg[5])))
        else $error("Wrong number of words read");
    a_cs_between_words: assert property (
        (state_reg == S_GAP) |=> !ee_cs)
        else $error("Chip select held between words");
    a_start_bit_out: assert property (
        (state_reg == S_SHIFT && bit_cnt_reg == 5'h00 && half_tick)
        |-> ee_di && ee_cs)
        else $error("Start bit not driven");
    a_setup_override: assert property (
        station_address_setup_cmd |=> ##1
        station_address == $past(setup_address, 2))
        else $error("Setup address not applied");
endmodule

/* hw/eeprom_loader_pkg.sv */
// Constants for the reset-time serial EEPROM configuration loader
package eeprom_loader_pkg;
    // Clock and serial clock timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SK_HALF_NS = 500;
    localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Serial frame layout per word
    localparam int CMD_BITS = 9;
    localparam int DUMMY_BITS = 1;
    localparam int DATA_BITS = 16;
    localparam int WORD_BITS = CMD_BITS + DUMMY_BITS + DATA_BITS;
    localparam logic START_BIT = 1'b1;
    localparam logic [1:0] READ_OPCODE = 2'b10;
    // EEPROM word addresses in read order
    localparam logic [5:0] EE_ADDR_CFG = 6'h0a;
    localparam logic [5:0] EE_ADDR_SUBSYS = 6'h0b;
    localparam logic [5:0] EE_ADDR_VENDOR = 6'h0c;
    localparam logic [5:0] EE_ADDR_SA0 = 6'h00;
    localparam logic [5:0] EE_ADDR_SA1 = 6'h01;
    localparam logic [5:0] EE_ADDR_SA2 = 6'h02;
    localparam logic [2:0] LAST_IDX_BASE = 3'h2;
    localparam logic [2:0] LAST_IDX_WOL = 3'h5;
    // Configuration word fields
    localparam int CFG_PHY_LSB = 0;
    localparam int CFG_WOL_BIT = 5;
    localparam int CFG_PM_BIT = 7;
    localparam int CFG_REV_LSB = 8;
    localparam int CFG_BOOT_BIT = 11;
    localparam int CFG_ID_BIT = 13;
    localparam int CFG_SIG_LSB = 14;
    localparam logic [1:0] SIG_VALID = 2'h1;
    localparam logic [2:0] SIG_ID_LATER = 3'h3;
    localparam logic [1:0] PHY_ADDR_DEFAULT = 2'h1;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    // Register map, 4-bit word addresses, 16-bit data
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CONFIG = 4'h1;
    localparam logic [3:0] REG_CONTROL = 4'h2;
    localparam logic [3:0] REG_SA0 = 4'h3;
    localparam logic [3:0] REG_SA1 = 4'h4;
    localparam logic [3:0] REG_SA2 = 4'h5;
    localparam logic [3:0] REG_SUBSYS = 4'h6;
    localparam logic [3:0] REG_VENDOR = 4'h7;
    localparam int ST_DONE = 0;
    localparam int ST_VALID = 1;
    localparam int ST_WOL = 2;
    localparam int ST_WAKE = 3;
    localparam int ST_SA_SW = 4;
    localparam int CTL_WAKE_CLR = 0;
    localparam int CTL_RELOAD = 1;
    // Loader states, one-hot
    typedef enum logic [2:0] {
        S_SHIFT = 3'b001,
        S_GAP = 3'b010,
        S_DONE = 3'b100
    } load_state_t;
endpackage

/* verification/eeprom_config_loader_tb.sv */
// Self-checking bench for the reset-time EEPROM configuration loader
`timescale 1ns/1ps
module eeprom_config_loader_tb;
    import eeprom_loader_pkg::*;
    // Short serial half period keeps each load near 216 cycles per word read
    localparam int SKH = 4;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic ee_cs, ee_sk, ee_di, ee_do;
    logic isolate_pin_n = 1'b0;
    logic clk_isolate;
    logic wake_packet_rx = 1'b0;
    logic wake_event_out_n;
    logic station_address_setup_cmd = 1'b0;
    logic [47:0] setup_address = 48'h0;
    logic rev_sub_strap = 1'b1;
    logic [1:0] phy_addr;
    logic wake_on_lan_enable, cap_ptr_zero, boot_rom_disable, subsys_id_sel;
    logic [7:0] revision_id;
    logic [15:0] subsystem_id, subsystem_vendor_id;
    logic [47:0] station_address;
    logic load_done;
    int frames, bad_cmd, miscompares = 0, tests_run = 0, cycles = 0;
    logic [35:0] addr_log;

    always #5 clk = ~clk;

    eeprom_config_loader #(.SK_HALF(SKH), .LATER_STEP(1'b1),
        .REV_ID_BASE(8'h40)) DUT (.clk, .sys_rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .ee_cs, .ee_sk, .ee_di, .ee_do,
        .isolate_pin_n, .clk_isolate, .wake_packet_rx, .wake_event_out_n,
        .station_address_setup_cmd, .setup_address, .rev_sub_strap,
        .phy_addr, .wake_on_lan_enable, .cap_ptr_zero, .boot_rom_disable,
        .subsys_id_sel, .revision_id, .subsystem_id, .subsystem_vendor_id,
        .station_address, .load_done);

    eeprom_model ee (.clk, .sys_rst, .ee_cs, .ee_sk, .ee_di, .ee_do,
        .frames, .addr_log, .bad_cmd);

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Four loads of up to six frames need well under this
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            test_done();
        end
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        tests_run++;
        if (reg_rdata !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time,
                reg_rdata, exp);
        end
    endtask

    task automatic wake_pulse();
        @(posedge clk);
        wake_packet_rx <= 1'b1;
        @(posedge clk);
        wake_packet_rx <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Reset for two cycles, then time the automatic load with isolation
    // held asserted, since the clock must not be gated meanwhile
    task automatic load(input logic [15:0] cfg, input int nw);
        int cyc;
        ee.mem[10] = cfg;
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        cyc = 0;
        while (load_done !== 1'b1 && cyc < 4000)
        begin
            @(posedge clk);
            #1;
            cyc++;
            if (cyc == 100)
                chk(clk_isolate, 1'b0);
        end
        chk(frames, nw);
        chk(bad_cmd, 0);
        chk(cyc >= nw * SKH * 52 && cyc <= nw * SKH * 54 + 16, 1);
    endtask

    initial
    begin
        ee.mem[11] = 16'h1234;
        ee.mem[12] = 16'habcd;
        ee.mem[0] = 16'h0201;
        ee.mem[1] = 16'h0403;
        ee.mem[2] = 16'h0605;
        // Valid word in wake mode, reserved bits zero, ID bit clear
        load(16'h4723, 6);
        chk(addr_log, {6'h0a, 6'h0b, 6'h0c, 6'h00, 6'h01, 6'h02});
        chk(station_address, 48'h060504030201);
        chk(phy_addr, 2'h3);
        chk({wake_on_lan_enable, cap_ptr_zero, boot_rom_disable,
            subsys_id_sel}, 4'h8);
        chk(revision_id, 8'h40);
        chk({subsystem_id, subsystem_vendor_id}, 32'h1234abcd);
        rd_chk(REG_CONFIG, 16'h4723);
        rd_chk(REG_STATUS, 16'h0007);
        rd_chk(REG_SA0, 16'h0201);
        rd_chk(REG_SA2, 16'h0605);
        rd_chk(REG_SA1, 16'h0403);
        rd_chk(REG_SUBSYS, 16'h1234);
        rd_chk(REG_VENDOR, 16'habcd);
        rd_chk(4'h9, 16'h0000);
        chk(clk_isolate, 1'b1);
        wake_pulse();
        chk(wake_event_out_n, 1'b0);
        rd_chk(REG_STATUS, 16'h000f);
        reg_write(REG_CONTROL, 16'h0001);
        repeat (2) @(posedge clk);
        #1;
        chk(wake_event_out_n, 1'b1);
        @(posedge clk);
        station_address_setup_cmd <= 1'b1;
        setup_address <= 48'ha1a2a3a4a5a6;
        @(posedge clk);
        station_address_setup_cmd <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(station_address, 48'ha1a2a3a4a5a6);
        rd_chk(REG_STATUS, 16'h0017);
        $display("test wake mode load finished");
        // Bad signature: PHY, wake, power, boot and ID bits set yet all defaults apply
        load(16'heba3, 3);
        chk(addr_log, {6'h0a, 6'h0b, 6'h0c});
        chk(phy_addr, 2'h1);
        chk({wake_on_lan_enable, cap_ptr_zero, boot_rom_disable,
            subsys_id_sel}, 4'h0);
        chk(revision_id, 8'h40);
        rd_chk(REG_STATUS, 16'h0001);
        wake_pulse();
        chk(wake_event_out_n, 1'b1);
        $display("test invalid signature finished");
        // Valid word with ID bit, power, boot and revision fields set
        load(16'h6d82, 3);
        chk(phy_addr, 2'h2);
        chk({wake_on_lan_enable, cap_ptr_zero, boot_rom_disable,
            subsys_id_sel}, 4'h7);
        chk(revision_id, 8'h45);
        rd_chk(REG_STATUS, 16'h0003);
        $display("test revision substitution finished");
        // Without the strap option the revision falls back to its base
        @(posedge clk);
        rev_sub_strap <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(revision_id, 8'h40);
        // Software reload repeats the sequence without a reset
        ee.mem[10] = 16'h4000;
        reg_write(REG_CONTROL, 16'h0002);
        @(posedge clk);
        #1;
        chk(load_done, 1'b0);
        repeat (700) @(posedge clk);
        #1;
        chk({load_done, phy_addr}, 3'h4);
        chk(frames, 6);
        chk(bad_cmd, 0);
        // Releasing isolation must drop the gating request
        @(posedge clk);
        isolate_pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(clk_isolate, 1'b0);
        $display("test strap, reload and isolation finished");
        test_done();
    end
endmodule

/* verification/eeprom_model.sv */
// Behavioural serial configuration EEPROM, 64 words of 16 bits
`timescale 1ns/1ps
module eeprom_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ee_cs,
    input wire logic ee_sk,
    input wire logic ee_di,
    output logic ee_do,
    output int frames,
    output logic [35:0] addr_log,
    output int bad_cmd
);
    logic [15:0] mem [64];
    logic [8:0] cmd;
    logic sk_q;
    logic cs_q;
    logic fall;
    int bitn;
    int nxt;
    // Lines come from the loader's flops, so sampling them on the system
    // clock sees every edge in order, one cycle late
    always @(posedge clk)
    begin
        sk_q <= ee_sk;
        cs_q <= ee_cs;
        fall = sk_q && !ee_sk;
        nxt = bitn + 1;
        if (sys_rst)
        begin
            frames <= 0;
            addr_log <= '0;
            bad_cmd <= 0;
        end
        // A frame must hold select for all 26 bit periods
        if (cs_q && !ee_cs)
        begin
            if (bitn + int'(fall) == 26)
                frames <= frames + 1;
            else
                bad_cmd <= bad_cmd + 1;
        end
        // Data line has a pull-up, so it idles high when not driven
        if (!ee_cs)
        begin
            bitn <= 0;
            ee_do <= 1'b1;
        end
        else if (ee_sk && !sk_q && bitn < 9)
            cmd <= {cmd[7:0], ee_di};
        else if (fall)
        begin
            bitn <= nxt;
            if (nxt == 9)
            begin
                ee_do <= 1'b0;
                addr_log <= {addr_log[29:0], cmd[5:0]};
                if (cmd[8:6] !== 3'b110)
                    bad_cmd <= bad_cmd + 1;
            end
            else if (nxt >= 10 && nxt <= 25)
                ee_do <= mem[cmd[5:0]][25 - nxt];
            else
                ee_do <= 1'b1;
        end
    end
endmodule
